// [rtl/ssc_ctrl.sv]
// Serial control registers, clock divider and 8-bit shifter behind an AXI4-Lite slave
//
// Added by the designer: the placing of the registers and the AXI4-Lite interface to the registers.
`include "ssc_defines.svh"
// Notes on behaviour
// - Disabled interface stops every internal clock except the enable register's.
// - Disabling keeps all programmed register contents.
// - Direction field: 00 transmit, 10 both, 11 receive, 01 reserved.
// - Transfer control bits 2-0 select serial clock source and rate.
// - Codes 000,001,010,100,110 divide fc by 2^3,2^4,2^5,2^7,2^9.
// - Lowest clock-select bit reads one until synchronous serial mode is chosen.
// - Each transfer moves exactly one 8-bit word.
// - Data writes load transmit buffer; reads return the receive buffer.
// - Transmit shifts most significant bit first.
// - Receive shifts in at the least significant bit.
// - Code 111 uses the external serial clock pin.
// - Interface mode: 00 port, 01 synchronous serial, 10 I2C, 11 reserved.
module ssc_ctrl #(
   parameter int FIFO_DEPTH = `SSC_FIFO_DEPTH
) (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // AXI4-Lite write address and data
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Serial pins
   input  wire logic        sck_in,
   output logic             sck_out,
   output logic             sck_oe,
   output logic             sdo,
   input  wire logic        sdi
);
   // Registers
   logic        enable_r;
   logic        start_r;
   logic        abort_r;
   logic [1:0]  dir_r;
   logic [2:0]  cksel_r;
   logic [1:0]  ifmode_r;
   logic        sio_seen_r;
   logic [7:0]  rxbuf_r;
   logic [7:0]  shift_r;
   logic [3:0]  bitcnt_r;
   logic [9:0]  div_r;
   logic        sck_r;
   logic        sdo_r;
   ssc_pkg::ssc_state_type state_r;
   ssc_pkg::ssc_state_type state_nxt;
   // Bus handshake state
   logic        aw_hold_r;
   logic        w_hold_r;
   logic [7:0]  awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0]  wstrb_r;
   logic        bvalid_r;
   logic [1:0]  bresp_r;
   logic        rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0]  rresp_r;
   // Pin synchronisers
   logic        sck_s1_r;
   logic        sck_s2_r;
   logic        sck_s3_r;
   logic        sdi_s1_r;
   logic        sdi_s2_r;

   ssc_fifo_if #(.WIDTH(8)) tx_in ();
   ssc_fifo_if #(.WIDTH(8)) tx_out ();

   ssc_fifo #(
      .WIDTH (8),
      .DEPTH (FIFO_DEPTH)
   ) u_txfifo (
      .aclk    (aclk),
      .aresetn (aresetn),
      .fill    (tx_in),
      .drain   (tx_out)
   );

   // Divider exponent per clock-select code
   function automatic logic [3:0] ssc_exp(input logic [2:0] code);
      case (code)
         3'h0:    ssc_exp = 4'h3;
         3'h1:    ssc_exp = 4'h4;
         3'h2:    ssc_exp = 4'h5;
         3'h4:    ssc_exp = 4'h7;
         3'h6:    ssc_exp = 4'h9;
         default: ssc_exp = 4'h0;
      endcase
   endfunction

   // Address decode
   function automatic logic [2:0] ssc_dec(input logic [7:0] a);
      case (a)
         `SSC_OFS_ENABLE: ssc_dec = 3'h1;
         `SSC_OFS_XFER:   ssc_dec = 3'h2;
         `SSC_OFS_DATA:   ssc_dec = 3'h3;
         `SSC_OFS_MODE:   ssc_dec = 3'h4;
         `SSC_OFS_STATUS: ssc_dec = 3'h5;
         default:         ssc_dec = 3'h0;
      endcase
   endfunction

   // Write path: address and data accepted in either order
   wire        wr_go    = aw_hold_r && w_hold_r && !bvalid_r;
   wire [2:0]  wr_sel   = ssc_dec(awaddr_r);
   wire        wr_lane0 = wstrb_r[0];
   wire [7:0]  wb       = wdata_r[7:0];
   wire        wr_en    = wr_go && wr_sel == 3'h1 && wr_lane0;
   wire        wr_xfer  = wr_go && wr_sel == 3'h2 && wr_lane0 && enable_r;
   wire        wr_data  = wr_go && wr_sel == 3'h3 && wr_lane0 && enable_r;
   wire        wr_mode  = wr_go && wr_sel == 3'h4 && wr_lane0 && enable_r;
   wire        wr_fifo_block = wr_data && !tx_in.ready;
   assign tx_in.valid = wr_data;
   assign tx_in.data  = wb;

   assign s_axi_awready = !aw_hold_r;
   assign s_axi_wready  = !w_hold_r;
   assign s_axi_bvalid  = bvalid_r;
   assign s_axi_bresp   = bresp_r;
   assign s_axi_arready = !rvalid_r;
   assign s_axi_rvalid  = rvalid_r;
   assign s_axi_rdata   = rdata_r;
   assign s_axi_rresp   = rresp_r;

   // Write channel capture and response; full FIFO stalls the response
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         w_hold_r  <= 1'b0;
         awaddr_r  <= 8'h00;
         wdata_r   <= 32'h0000_0000;
         wstrb_r   <= 4'h0;
         bvalid_r  <= 1'b0;
         bresp_r   <= `SSC_RESP_OKAY;
      end else begin
         if (s_axi_awvalid && !aw_hold_r) begin
            aw_hold_r <= 1'b1;
            awaddr_r  <= s_axi_awaddr;
         end
         if (s_axi_wvalid && !w_hold_r) begin
            w_hold_r <= 1'b1;
            wdata_r  <= s_axi_wdata;
            wstrb_r  <= s_axi_wstrb;
         end
         if (wr_go && !wr_fifo_block) begin
            aw_hold_r <= 1'b0;
            w_hold_r  <= 1'b0;
            bvalid_r  <= 1'b1;
            bresp_r   <= (wr_sel == 3'h0) ? `SSC_RESP_SLVERR : `SSC_RESP_OKAY;
         end else if (s_axi_bready) begin
            bvalid_r <= 1'b0;
         end
      end
   end

   // Read mux
   wire [2:0]  rd_sel = ssc_dec(s_axi_araddr);
   wire        busy   = (state_r != ssc_pkg::SSC_ST_IDLE);
   // low select bit reads one before serial mode
   wire [2:0]  cksel_rd = {cksel_r[2:1], sio_seen_r ? cksel_r[0] : 1'b1};
   // upper bits zero, bit 3 one
   wire [31:0] rd_xfer  = {24'h00_0000, start_r, abort_r, dir_r, 1'b1, cksel_rd};
   wire [31:0] rd_mux   =
      (rd_sel == 3'h1) ? {24'h00_0000, enable_r, 7'h00} :
      (rd_sel == 3'h2) ? rd_xfer :
      (rd_sel == 3'h3) ? {24'h00_0000, rxbuf_r} :
      (rd_sel == 3'h4) ? {28'h000_0000, ifmode_r, 2'h0} :
      (rd_sel == 3'h5) ? {28'h000_0000, start_r || busy, busy, tx_out.valid, tx_in.ready} :
      32'h0000_0000;

   // Read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_r <= 1'b0;
         rdata_r  <= 32'h0000_0000;
         rresp_r  <= `SSC_RESP_OKAY;
      end else if (s_axi_arvalid && !rvalid_r) begin
         rvalid_r <= 1'b1;
         rdata_r  <= rd_mux;
         rresp_r  <= (rd_sel == 3'h0) ? `SSC_RESP_SLVERR : `SSC_RESP_OKAY;
      end else if (s_axi_rready) begin
         rvalid_r <= 1'b0;
      end
   end

   // Control registers; no clear on disable, writes gated only
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         enable_r   <= 1'b0;
         start_r    <= 1'b0;
         abort_r    <= 1'b0;
         dir_r      <= 2'h0;
         cksel_r    <= `SSC_CKSEL_RST;
         ifmode_r   <= `SSC_MODE_RST;
         sio_seen_r <= 1'b0;
      end else begin
         if (wr_en) enable_r <= wb[`SSC_EN_BIT];
         if (wr_xfer) begin
            start_r <= wb[`SSC_START_BIT];
            abort_r <= wb[`SSC_ABORT_BIT];
            dir_r   <= wb[`SSC_DIR_HI:`SSC_DIR_LO];
            cksel_r <= wb[`SSC_CKSEL_HI:`SSC_CKSEL_LO];
         end
         if (wr_mode) begin
            ifmode_r <= wb[`SSC_MODE_HI:`SSC_MODE_LO];
            // serial mode clears the reset-time select bit
            if (wb[`SSC_MODE_HI:`SSC_MODE_LO] == `SSC_MODE_SIO && !sio_seen_r) begin
               sio_seen_r <= 1'b1;
               cksel_r[0] <= 1'b0;
            end
         end
      end
   end

   // Pin synchronisers; the third stage only feeds edge detection
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sck_s1_r <= 1'b1;
         sck_s2_r <= 1'b1;
         sck_s3_r <= 1'b1;
         sdi_s1_r <= 1'b0;
         sdi_s2_r <= 1'b0;
      end else begin
         sck_s1_r <= sck_in;
         sck_s2_r <= sck_s1_r;
         sck_s3_r <= sck_s2_r;
         sdi_s1_r <= sdi;
         sdi_s2_r <= sdi_s1_r;
      end
   end

   // Shift tick decoding: half period of fc/2^n, or external edges
   wire        dir_tx   = (dir_r == ssc_pkg::SSC_DIR_TX) || (dir_r == ssc_pkg::SSC_DIR_TRX);
   wire        dir_ok   = (dir_r != ssc_pkg::SSC_DIR_RSV);
   wire        sio_mode = (ifmode_r == ssc_pkg::SSC_IF_SIO);
   wire        ext_clk  = (cksel_r == `SSC_CKSEL_EXT);
   wire [3:0]  n_exp    = ssc_exp(cksel_r);
   // half period reached at 2^(n-1) cycles
   wire        half_tick = (n_exp != 4'h0) &&
                           (div_r == 10'((11'h001 << (n_exp - 4'h1)) - 11'h001));
   wire        ext_fall = sck_s3_r && !sck_s2_r;
   wire        ext_rise = !sck_s3_r && sck_s2_r;
   wire        tick_fall = ext_clk ? ext_fall : (half_tick && sck_r);
   wire        tick_rise = ext_clk ? ext_rise : (half_tick && !sck_r);
   wire        need_tx  = dir_tx;
   wire        can_go   = enable_r && sio_mode && start_r && !abort_r && dir_ok &&
                          (!need_tx || tx_out.valid);
   wire        last_bit = (bitcnt_r == `SSC_WORD_BITS - 4'h1);
   assign tx_out.ready = (state_r == ssc_pkg::SSC_ST_IDLE) && can_go && need_tx;

   // Shifter state sequence
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         ssc_pkg::SSC_ST_IDLE: if (can_go) state_nxt = ssc_pkg::SSC_ST_HIGH;
         ssc_pkg::SSC_ST_HIGH: if (tick_fall) state_nxt = ssc_pkg::SSC_ST_LOW;
         ssc_pkg::SSC_ST_LOW:  if (tick_rise) state_nxt = last_bit ?
                                  ssc_pkg::SSC_ST_DONE : ssc_pkg::SSC_ST_HIGH;
         // next word only while start stays set
         ssc_pkg::SSC_ST_DONE: state_nxt = ssc_pkg::SSC_ST_IDLE;
         default:              state_nxt = ssc_pkg::SSC_ST_IDLE;
      endcase
   end

   // Divider and shifter; state, divider and count cleared and clock held high while disabled
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         state_r  <= ssc_pkg::SSC_ST_IDLE;
         div_r    <= 10'h000;
         sck_r    <= 1'b1;
         shift_r  <= 8'h00;
         bitcnt_r <= 4'h0;
         rxbuf_r  <= 8'h00;
         sdo_r    <= 1'b1;
      end else if (abort_r || !enable_r) begin
         state_r  <= ssc_pkg::SSC_ST_IDLE;
         div_r    <= 10'h000;
         sck_r    <= 1'b1;
         bitcnt_r <= 4'h0;
      end else begin
         state_r <= state_nxt;
         div_r   <= (half_tick || state_r == ssc_pkg::SSC_ST_IDLE) ? 10'h000 : div_r + 10'h001;
         if (state_r == ssc_pkg::SSC_ST_IDLE && can_go) begin
            shift_r  <= need_tx ? tx_out.data : 8'h00;
            bitcnt_r <= 4'h0;
            sck_r    <= 1'b1;
         end
         if (tick_fall && state_r == ssc_pkg::SSC_ST_HIGH) begin
            sck_r <= 1'b0;
            sdo_r <= dir_tx ? shift_r[7] : 1'b1;
         end
         if (tick_rise && state_r == ssc_pkg::SSC_ST_LOW) begin
            sck_r    <= 1'b1;
            shift_r  <= {shift_r[6:0], sdi_s2_r};
            bitcnt_r <= bitcnt_r + 4'h1;
         end
         if (state_r == ssc_pkg::SSC_ST_DONE && dir_r != ssc_pkg::SSC_DIR_TX) begin
            rxbuf_r <= shift_r;
         end
      end
   end

   // Pin drive: clock driven only when internally generated
   assign sck_out = sck_r;
   assign sck_oe  = enable_r && sio_mode && !ext_clk;
   assign sdo     = sdo_r;
endmodule // ssc_ctrl

// [rtl/ssc_defines.svh]
// Register offsets, field positions, reset values and timing for the serial control block
`ifndef SSC_DEFINES_SVH
`define SSC_DEFINES_SVH
`define SSC_OFS_ENABLE      8'h00
`define SSC_OFS_XFER        8'h04
`define SSC_OFS_DATA        8'h08
`define SSC_OFS_MODE        8'h0C
`define SSC_OFS_STATUS      8'h10
`define SSC_EN_BIT          7
`define SSC_START_BIT       7
`define SSC_ABORT_BIT       6
`define SSC_DIR_HI          5
`define SSC_DIR_LO          4
`define SSC_FIXED_ONE_BIT   3
`define SSC_CKSEL_HI        2
`define SSC_CKSEL_LO        0
`define SSC_MODE_HI         3
`define SSC_MODE_LO         2
`define SSC_CKSEL_RST       3'h1
`define SSC_MODE_RST        2'h0
`define SSC_MODE_SIO        2'h1
`define SSC_CKSEL_EXT       3'h7
`define SSC_FC_HZ           40000000
`define SSC_WORD_BITS       4'h8
`define SSC_FIFO_DEPTH      8
`define SSC_RESP_OKAY       2'h0
`define SSC_RESP_SLVERR     2'h2
`endif

// [rtl/ssc_pkg.sv]
// Types shared by the serial control block
package ssc_pkg;
   typedef enum logic [1:0] {
      SSC_DIR_TX   = 2'h0,
      SSC_DIR_RSV  = 2'h1,
      SSC_DIR_TRX  = 2'h2,
      SSC_DIR_RX   = 2'h3
   } ssc_dir_type;
   typedef enum logic [1:0] {
      SSC_IF_PORT  = 2'h0,
      SSC_IF_SIO   = 2'h1,
      SSC_IF_I2C   = 2'h2,
      SSC_IF_RSV   = 2'h3
   } ssc_ifmode_type;
   typedef enum logic [1:0] {
      SSC_ST_IDLE  = 2'h0,
      SSC_ST_LOW   = 2'h3,
      SSC_ST_HIGH  = 2'h1,
      SSC_ST_DONE  = 2'h2
   } ssc_state_type;
endpackage

// [rtl/ssc_fifo_if.sv]
// Valid/ready stream carrier between the register block and its transmit FIFO
interface ssc_fifo_if #(parameter int WIDTH = 8);
   logic             valid;
   logic             ready;
   logic [WIDTH-1:0] data;
   modport source (output valid, output data, input ready);
   modport sink   (input valid, input data, output ready);
endinterface

// [rtl/ssc_fifo.sv]
// Synchronous FIFO with valid/ready on both sides
module ssc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // Clock and reset
   input wire logic aclk,
   input wire logic aresetn,
   // Fill and drain sides
   ssc_fifo_if.sink   fill,
   ssc_fifo_if.source drain
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0]    wptr_r;
   logic [AW-1:0]    rptr_r;
   logic [AW:0]      count_r;
   wire              push = fill.valid && fill.ready;
   wire              pop  = drain.valid && drain.ready;
   // Honest full and empty from the count
   assign fill.ready  = (count_r != (AW+1)'(DEPTH));
   assign drain.valid = (count_r != '0);
   assign drain.data  = mem[rptr_r];
   // Storage, no reset needed
   always_ff @(posedge aclk) begin
      if (push) begin
         mem[wptr_r] <= fill.data;
      end
   end
   // Pointers and occupancy
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         wptr_r  <= '0;
         rptr_r  <= '0;
         count_r <= '0;
      end else begin
         if (push) wptr_r <= (wptr_r == AW'(DEPTH-1)) ? '0 : wptr_r + 1'b1;
         if (pop)  rptr_r <= (rptr_r == AW'(DEPTH-1)) ? '0 : rptr_r + 1'b1;
         count_r <= count_r + (AW+1)'(push) - (AW+1)'(pop);
      end
   end
endmodule // ssc_fifo

// [tb/ssc_ctrl_properties.sv]
// Bus and serial pin properties of the serial control block
`include "ssc_defines.svh"
module ssc_ctrl_checker #(
   parameter int FIFO_DEPTH = 8
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Serial pins
   input wire logic        sck_out,
   input wire logic        sck_oe,
   input wire logic        sdo
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Address and data taken together
   sequence s_aw_w;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   // Driven serial clock just rose
   sequence s_sck_up;
      sck_oe && $rose(sck_out);
   endsequence
   // Non-data writes never stall
   property p_wr_resp;
      s_aw_w ##0 (s_axi_awaddr != `SSC_OFS_DATA) |-> ##2 s_axi_bvalid;
   endproperty
   a_wr_resp: assert property (p_wr_resp) else $error("write response late");
   property p_b_stand;
      s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
   endproperty
   a_b_stand: assert property (p_b_stand) else $error("write response dropped");
   property p_r_stand;
      s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
   endproperty
   a_r_stand: assert property (p_r_stand) else $error("read data dropped");
   property p_rd_resp;
      s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
   endproperty
   a_rd_resp: assert property (p_rd_resp) else $error("read response late");
   property p_ar_busy;
      s_axi_rvalid |-> !s_axi_arready;
   endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("second read accepted");
   property p_hi_bits;
      s_axi_rvalid && s_axi_rresp == `SSC_RESP_OKAY |-> s_axi_rdata[31:8] == 24'h0;
   endproperty
   a_hi_bits: assert property (p_hi_bits) else $error("upper bits set");
   property p_err_zero;
      s_axi_rvalid && s_axi_rresp == `SSC_RESP_SLVERR |-> s_axi_rdata == 32'h0;
   endproperty
   a_err_zero: assert property (p_err_zero) else $error("error read not zero");
   // Shortest divider gives four cycles a phase
   property p_half;
      s_sck_up |=> $stable(sck_out)[*3];
   endproperty
   a_half: assert property (p_half) else $error("serial clock phase short");
   property p_rst;
      $rose(aresetn) |-> sck_out && sdo && !sck_oe;
   endproperty
   a_rst: assert property (p_rst) else $error("pins not idle after reset");
endmodule // ssc_ctrl_checker
bind ssc_ctrl ssc_ctrl_checker #(.FIFO_DEPTH(FIFO_DEPTH)) u_ssc_ctrl_checker (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
   .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_arvalid(s_axi_arvalid),
   .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .sck_out(sck_out),
   .sck_oe(sck_oe), .sdo(sdo));

// [tb/ssc_peer.sv]
// Far-side serial peripheral: shifts one byte out, captures the device's bits
module ssc_peer (
   // Clock and control
   input  wire logic       aclk,
   input  wire logic       ext_en,
   input  wire logic       load,
   input  wire logic [7:0] tx,
   // Serial pins
   input  wire logic       sck_oe,
   input  wire logic       sck_out,
   input  wire logic       sdo,
   output logic            sck_in = 1'h1,
   output logic            sdi = 1'h1,
   output logic [7:0]      rx = 8'h00,
   output int              nb = 0
);
   logic       sck;
   logic       sck_q = 1'h1;
   logic [7:0] sh = 8'h00;
   int         dv = 0;
   int         q = 0;
   // Pin level from whichever side drives it
   assign sck = sck_oe ? sck_out : sck_in;
   // Edge detection on the pin, one aclk late
   always @(posedge aclk) begin
      dv <= dv + 1;
      sck_q <= sck;
      q <= (sck_q != sck) ? 0 : q + 1;
      // External clock toggles only inside a frame
      if (ext_en && !(nb == 8 && sck_in) && dv % 8 == 7)
         sck_in <= !sck_in;
      if (load) begin
         sh <= tx;
         nb <= 0;
      end else if (sck_q && !sck) begin
         sdi <= sh[7];
         sh <= {sh[6:0], 1'h0};
      end else if (!sck_q && sck) begin
         rx <= {rx[6:0], sdo};
         nb <= nb + 1;
      end else if (q > 6 && sck && nb % 8 == 0)
         sdi <= !sdi;  // Only between frames: no stale level on a released line
   end
endmodule // ssc_peer

// [tb/testbench.sv]
// Self-checking bench for the serial control block
`include "ssc_defines.svh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        aclk = 1'h0, aresetn = 1'h0, ext_en = 1'h0, load = 1'h0;
   logic        awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [7:0]  awaddr = 8'h00, araddr = 8'h00, ptx = 8'h00, prx;
   logic [31:0] wdata = 32'h0, rdata, v;
   logic        awready, wready, bvalid, arready, rvalid, sck_in, sck_out, sck_oe, sdo, sdi;
   logic [1:0]  bresp, rresp, r;
   logic [7:0]  txq[$], rxq[$];
   int          pnb, nb_q = 0, fails = 0, n_tests = 0, cyc = 0, seed, ctrl_m, rxb_m = 0;
   int          codes[6] = '{7, 0, 1, 2, 4, 6};
   int          dirs[6] = '{2, 2, 0, 3, 2, 3};
   logic        pin;
   assign pin = sck_oe ? sck_out : sck_in;
   initial forever #12.5 aclk = ~aclk;
   ssc_ctrl u_ssc_ctrl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sck_in(sck_in),
      .sck_out(sck_out), .sck_oe(sck_oe), .sdo(sdo), .sdi(sdi));
   ssc_peer u_ssc_peer (.aclk(aclk), .ext_en(ext_en), .load(load), .tx(ptx), .sck_oe(sck_oe),
      .sck_out(sck_out), .sdo(sdo), .sck_in(sck_in), .sdi(sdi), .rx(prx), .nb(pnb));
   // Collect every whole byte the peer saw; cut a hang short
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      nb_q <= pnb;
      if (pnb != nb_q && pnb % 8 == 0 && pnb != 0)
         rxq.push_back(prx);
      if (cyc == 60000) begin
         fails++;
         test_done;
      end
   end
   task automatic chk(string s, logic [31:0] seen, logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         $display("ERROR %s expected %h seen %h", s, exp, seen);
         fails++;
      end
   endtask
   // Both channels offered together, each released when taken
   task automatic wr(logic [7:0] a, logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      {awvalid, wvalid, bready} <= 3'h7;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (bvalid !== 1'h1);
      resp = bresp;
      bready <= 1'h0;
   endtask
   task automatic rd(logic [7:0] a, output logic [31:0] d, output logic [1:0] resp);
      @(posedge aclk);
      araddr <= a;
      {arvalid, rready} <= 2'h3;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (rvalid !== 1'h1);
      d = rdata;
      resp = rresp;
      rready <= 1'h0;
   endtask
   task automatic w(logic [7:0] a, logic [31:0] d);
      wr(a, d, r);
      chk("bresp", r, `SSC_RESP_OKAY);
   endtask
   task automatic rc(string s, logic [7:0] a, logic [31:0] e);
      rd(a, v, r);
      chk(s, v, e);
   endtask
   task automatic idle;
      do rd(`SSC_OFS_STATUS, v, r); while (v[3:2] !== 2'h0);
   endtask
   // One word in a given clock code and direction, timed on the pin
   task automatic xfer(int code, int dir);
      int h;
      logic [7:0] d, p;
      h = 0;
      d = $random(seed);
      p = $random(seed);
      ctrl_m = 8'h48 | dir << 4 | code;
      w(`SSC_OFS_XFER, ctrl_m);
      if (dir != 3) w(`SSC_OFS_DATA, {24'hFFFFFF, d});
      ptx <= p;
      load <= 1'h1;
      @(posedge aclk);
      load <= 1'h0;
      ctrl_m = ctrl_m & 8'h3F | 8'h80;
      w(`SSC_OFS_XFER, ctrl_m);
      ext_en <= (code == 7);
      // Second low phase is timed whole
      while (pin !== 1'h0) @(posedge aclk);
      while (pin !== 1'h1) @(posedge aclk);
      while (pin !== 1'h0) @(posedge aclk);
      while (pin !== 1'h1) begin
         @(posedge aclk);
         h++;
      end
      chk("half period", h, code == 7 ? 8 : 1 << (code + 2));
      chk("pin drive", sck_oe, code != 7);
      ctrl_m = ctrl_m & 8'h3F;
      w(`SSC_OFS_XFER, ctrl_m);
      idle;
      ext_en <= 1'h0;
      if (dir >= 2) rxb_m = p;
      chk("bits", pnb, 8);
      chk("peer byte", prx, dir == 3 ? 8'hFF : d);
      rc("rx buffer", `SSC_OFS_DATA, rxb_m);
      rc("ctrl", `SSC_OFS_XFER, ctrl_m);
      chk("sdo idle", sdo, dir == 3 ? 1'h1 : d[0]);
      $display("word code %0d dir %0d done", code, dir);
   endtask
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // Main sequence
   initial begin
      seed = 32'h0263A97D;
      repeat (4) @(posedge aclk);
      aresetn <= 1'h1;
      rc("enable", `SSC_OFS_ENABLE, 32'h0);
      rc("ctrl", `SSC_OFS_XFER, 32'h9);
      rd(8'h40, v, r);
      chk("unmapped read", r, `SSC_RESP_SLVERR);
      wr(8'h40, 32'h1, r);
      chk("unmapped write", r, `SSC_RESP_SLVERR);
      w(`SSC_OFS_XFER, 32'h30);
      rc("ctrl gated", `SSC_OFS_XFER, 32'h9);
      w(`SSC_OFS_ENABLE, 32'hFFFFFFFF);
      rc("enable", `SSC_OFS_ENABLE, 32'h80);
      w(`SSC_OFS_MODE, 32'h4);
      rc("ctrl serial", `SSC_OFS_XFER, 32'h8);
      $display("register test done");
      foreach (codes[i]) xfer(codes[i], dirs[i]);
      w(`SSC_OFS_ENABLE, 32'h0);
      chk("oe gated", sck_oe, 1'h0);
      rc("ctrl kept", `SSC_OFS_XFER, ctrl_m);
      w(`SSC_OFS_ENABLE, 32'h80);
      // Fill the transmit buffer, then drain it over the wire
      w(`SSC_OFS_XFER, 32'h40);
      rxq.delete();
      repeat (8) begin
         v = $random(seed);
         txq.push_back(v[7:0]);
         w(`SSC_OFS_DATA, v); // whole writes, never read back
      end
      rc("status full", `SSC_OFS_STATUS, 32'h2);
      w(`SSC_OFS_XFER, 32'h80);
      do rd(`SSC_OFS_STATUS, v, r); while (v[1] !== 1'h0);
      w(`SSC_OFS_XFER, 32'h0);
      idle;
      chk("words", rxq.size(), 8);
      foreach (txq[i]) chk("fifo byte", rxq[i], txq[i]);
      $display("buffer test done");
      w(`SSC_OFS_DATA, 32'hA5);
      w(`SSC_OFS_XFER, 32'h80);
      while (sck_out !== 1'h0) @(posedge aclk);
      w(`SSC_OFS_XFER, 32'h40);
      repeat (2) @(posedge aclk);
      chk("abort sck", sck_out, 1'h1);
      rd(`SSC_OFS_STATUS, v, r);
      chk("abort busy", v[2], 1'h0);
      // Reserved direction never starts a word
      w(`SSC_OFS_XFER, 32'h90);
      repeat (20) @(posedge aclk);
      rd(`SSC_OFS_STATUS, v, r);
      chk("reserved busy", v[2], 1'h0);
      chk("reserved sck", sck_out, 1'h1);
      $display("abort test done");
      test_done;
   end
endmodule // testbench
